/* slm_pkg.sv */
// Constants and register map for the loop-back steering block
package slm_pkg;
    localparam int SLM_AW = 8;
    localparam logic [7:0] SLM_CTRL_OFS = 8'h00;
    localparam logic [7:0] SLM_CMD_OFS = 8'h04;
    localparam logic [7:0] SLM_STAT_OFS = 8'h08;
    localparam logic [7:0] SLM_CTRL_RST = 8'h00;
    localparam logic [7:0] SLM_CMD_RST = 8'h00;
    localparam int SLM_CTRL_DIV_LSB = 0;
    localparam int SLM_CTRL_DIV_MSB = 3;
    localparam int SLM_CTRL_SHARED_CLK = 4;
    localparam int SLM_CTRL_LOOP = 5;
    localparam int SLM_CMD_ENA = 0;
    localparam int SLM_CMD_RX_IRQ = 1;
    localparam int SLM_CMD_TXC_LSB = 2;
    localparam int SLM_CMD_TXC_MSB = 3;
    localparam int SLM_CMD_ECHO = 4;
    localparam logic [3:0] SLM_DIV_EXT = 4'h0;
    localparam logic [1:0] SLM_TXC_QUIET = 2'h2;
    localparam int SLM_EXT_DIV = 16;
    localparam int SLM_ST_LOOP = 0;
    localparam int SLM_ST_ECHO = 1;
    localparam int SLM_ST_REMOTE_OK = 2;
    localparam int SLM_ST_EXT_MODE = 3;
    localparam int SLM_ST_MDM_LSB = 4;
    localparam int SLM_ST_ADP_LSB = 8;
    // Sync vector layout
    localparam int SLM_SYNC_W = 9;
    localparam int SLM_I_MRXD = 0;
    localparam int SLM_I_MDCD = 1;
    localparam int SLM_I_MCTS = 2;
    localparam int SLM_I_MDSR = 3;
    localparam int SLM_I_ATXD = 4;
    localparam int SLM_I_ADTR = 5;
    localparam int SLM_I_ARTS = 6;
    localparam int SLM_I_LOOP = 7;
    localparam int SLM_I_EXT = 8;
    // Lines idle high, loop pin and ext clock low
    localparam logic [8:0] SLM_SYNC_RST = 9'h07F;
    localparam logic SLM_MARK = 1'b1;
    localparam logic SLM_DEASSERT = 1'b1;
    localparam logic SLM_ASSERT = 1'b0;
endpackage

/* slm_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module slm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] dout_reg;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] dout_next;

    // Stage one is read only by stage two
    assign agree = ~(s2_reg ^ s3_reg);
    assign dout_next = (agree & s3_reg) | (~agree & dout_reg);
    assign dout = dout_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            dout_reg <= RST_VAL;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            dout_reg <= dout_next;
        end
    end
endmodule

/* slm_top.sv */
// Local and remote loop-back steering between adapter and modem
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module slm_top
    import slm_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [SLM_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LOCAL_LOOP_SELECT,
    input wire logic EXT_CLK,
    input wire logic ADP_TXD,
    input wire logic ADP_DTR_N,
    input wire logic ADP_RTS_N,
    output logic ADP_RXD,
    output logic ADP_DCD_N,
    output logic ADP_CTS_N,
    output logic ADP_DSR_N,
    output logic MDM_TXD,
    output logic MDM_DTR_N,
    output logic MDM_RTS_N,
    input wire logic MDM_RXD,
    input wire logic MDM_DCD_N,
    input wire logic MDM_CTS_N,
    input wire logic MDM_DSR_N,
    output logic BIT_TICK
);
    logic [SLM_SYNC_W-1:0] pins_raw;
    logic [SLM_SYNC_W-1:0] pins_s;
    logic mdm_rxd_s;
    logic mdm_dcd_s;
    logic mdm_cts_s;
    logic mdm_dsr_s;
    logic adp_txd_s;
    logic adp_dtr_s;
    logic adp_rts_s;
    logic loop_pin_s;
    logic ext_s;

    logic [7:0] ctrl_reg;
    logic [7:0] cmd_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic loop_on;
    logic echo_on;
    logic remote_ok;
    logic ext_mode;

    logic mdm_txd_reg;
    logic mdm_dtr_reg;
    logic mdm_rts_reg;
    logic adp_rxd_reg;
    logic adp_dcd_reg;
    logic adp_cts_reg;
    logic adp_dsr_reg;
    logic mdm_txd_next;
    logic mdm_dtr_next;
    logic mdm_rts_next;
    logic adp_rxd_next;
    logic adp_dcd_next;
    logic adp_cts_next;
    logic adp_dsr_next;

    logic ext_prev_reg;
    logic ext_rise;
    logic [3:0] tick_cnt_reg;
    logic [3:0] tick_cnt_next;
    logic tick_hit;
    logic bit_tick_reg;

    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_cmd;
    logic hit_stat;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_cmd;
    logic [31:0] stat_word;
    logic [31:0] rd_next;

    // All line pins, EXT_CLK and the loop control cross in through one filter; the APB pins do not
    assign pins_raw = {EXT_CLK, LOCAL_LOOP_SELECT, ADP_RTS_N, ADP_DTR_N,
                       ADP_TXD, MDM_DSR_N, MDM_CTS_N, MDM_DCD_N, MDM_RXD};

    slm_sync #(
        .WIDTH(SLM_SYNC_W),
        .RST_VAL(SLM_SYNC_RST)
    ) u_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign mdm_rxd_s = pins_s[SLM_I_MRXD];
    assign mdm_dcd_s = pins_s[SLM_I_MDCD];
    assign mdm_cts_s = pins_s[SLM_I_MCTS];
    assign mdm_dsr_s = pins_s[SLM_I_MDSR];
    assign adp_txd_s = pins_s[SLM_I_ATXD];
    assign adp_dtr_s = pins_s[SLM_I_ADTR];
    assign adp_rts_s = pins_s[SLM_I_ARTS];
    assign loop_pin_s = pins_s[SLM_I_LOOP];
    assign ext_s = pins_s[SLM_I_EXT];

    // pin or register bit may drive it
    assign loop_on = loop_pin_s | ctrl_reg[SLM_CTRL_LOOP];
    assign echo_on = cmd_reg[SLM_CMD_ECHO] & ~loop_on;
    assign remote_ok = echo_on & ctrl_reg[SLM_CTRL_SHARED_CLK]
        & (cmd_reg[SLM_CMD_TXC_MSB:SLM_CMD_TXC_LSB] == SLM_TXC_QUIET)
        & ~cmd_reg[SLM_CMD_RX_IRQ];
    assign ext_mode =
        (ctrl_reg[SLM_CTRL_DIV_MSB:SLM_CTRL_DIV_LSB] == SLM_DIV_EXT);

    // modem side held idle in loop-back
    // echo takes received data straight back out
    assign mdm_txd_next = loop_on ? SLM_MARK :
                          (echo_on ? mdm_rxd_s : adp_txd_s);
    assign mdm_dtr_next = loop_on ? SLM_DEASSERT : adp_dtr_s;
    assign mdm_rts_next = loop_on ? SLM_DEASSERT :
                          (echo_on ? SLM_ASSERT : adp_rts_s);
    assign adp_rxd_next = loop_on ? adp_txd_s : mdm_rxd_s;
    assign adp_dcd_next = loop_on ? adp_dtr_s : mdm_dcd_s;
    assign adp_cts_next = loop_on ? adp_rts_s : mdm_cts_s;
    // No partner for DSR in loop-back, so it reads inactive
    assign adp_dsr_next = loop_on ? SLM_DEASSERT : mdm_dsr_s;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mdm_txd_reg <= SLM_MARK;
            mdm_dtr_reg <= SLM_DEASSERT;
            mdm_rts_reg <= SLM_DEASSERT;
            adp_rxd_reg <= SLM_MARK;
            adp_dcd_reg <= SLM_DEASSERT;
            adp_cts_reg <= SLM_DEASSERT;
            adp_dsr_reg <= SLM_DEASSERT;
        end else begin
            mdm_txd_reg <= mdm_txd_next;
            mdm_dtr_reg <= mdm_dtr_next;
            mdm_rts_reg <= mdm_rts_next;
            adp_rxd_reg <= adp_rxd_next;
            adp_dcd_reg <= adp_dcd_next;
            adp_cts_reg <= adp_cts_next;
            adp_dsr_reg <= adp_dsr_next;
        end
    end

    // one bit tick per sixteen external rising edges
    assign ext_rise = ext_s & ~ext_prev_reg;
    assign tick_hit = ext_rise & ext_mode &
        (tick_cnt_reg == 4'(SLM_EXT_DIV - 1));
    // Count freezes outside external mode so the phase is kept
    assign tick_cnt_next = (ext_rise & ext_mode) ?
        4'(tick_cnt_reg + 4'h1) : tick_cnt_reg;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_prev_reg <= 1'b0;
            tick_cnt_reg <= 4'h0;
            bit_tick_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_s;
            tick_cnt_reg <= tick_cnt_next;
            bit_tick_reg <= tick_hit;
        end
    end

    // APB decode, zero wait states
    assign setup_ph = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign hit_ctrl = (PADDR == SLM_CTRL_OFS);
    assign hit_cmd = (PADDR == SLM_CMD_OFS);
    assign hit_stat = (PADDR == SLM_STAT_OFS);
    assign addr_ok = hit_ctrl | hit_cmd | hit_stat;
    assign wr_ctrl = access_ph & PWRITE & hit_ctrl;
    assign wr_cmd = access_ph & PWRITE & hit_cmd;

    assign stat_word = (32'(loop_on) << SLM_ST_LOOP)
        | (32'(echo_on) << SLM_ST_ECHO)
        | (32'(remote_ok) << SLM_ST_REMOTE_OK)
        | (32'(ext_mode) << SLM_ST_EXT_MODE)
        | (32'({mdm_dsr_s, mdm_cts_s, mdm_dcd_s, mdm_rxd_s})
            << SLM_ST_MDM_LSB)
        | (32'({adp_rts_s, adp_dtr_s, adp_txd_s}) << SLM_ST_ADP_LSB);

    // Read data prepared in setup so PRDATA is a flop in access
    assign rd_next = hit_ctrl ? 32'(ctrl_reg) :
                     hit_cmd ? 32'(cmd_reg) :
                     hit_stat ? stat_word : 32'h0000_0000;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= SLM_CTRL_RST;
            cmd_reg <= SLM_CMD_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (wr_ctrl) begin
                ctrl_reg <= PWDATA[7:0];
            end
            if (wr_cmd) begin
                cmd_reg <= PWDATA[7:0];
            end
            if (setup_ph) begin
                prdata_reg <= PWRITE ? 32'h0000_0000 : rd_next;
                pslverr_reg <= ~addr_ok;
            end
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign ADP_RXD = adp_rxd_reg;
    assign ADP_DCD_N = adp_dcd_reg;
    assign ADP_CTS_N = adp_cts_reg;
    assign ADP_DSR_N = adp_dsr_reg;
    assign MDM_TXD = mdm_txd_reg;
    assign MDM_DTR_N = mdm_dtr_reg;
    assign MDM_RTS_N = mdm_rts_reg;
    assign BIT_TICK = bit_tick_reg;

    // Checking helper: external rises since the last tick
    logic [4:0] rises_since_reg;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rises_since_reg <= 5'h00;
        end else if (bit_tick_reg) begin
            rises_since_reg <= (ext_rise & ext_mode) ? 5'h01 : 5'h00;
        end else if (ext_rise & ext_mode) begin
            rises_since_reg <= 5'(rises_since_reg + 5'h01);
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence loop_pin_held;
        LOCAL_LOOP_SELECT [*5];
    endsequence

    // pin high reaches the modem side in five edges
    AST_LOOP_PIN_ACTS: assert property (
        loop_pin_held |=> MDM_TXD == SLM_MARK
            && MDM_DTR_N == SLM_DEASSERT)
        else $error("loop pin did not cut modem outputs");

    AST_LOOP_TX_CUT: assert property (
        loop_on |=> MDM_TXD == SLM_MARK && MDM_DTR_N == SLM_DEASSERT
            && MDM_RTS_N == SLM_DEASSERT)
        else $error("adapter output leaked to modem in loop-back");

    AST_LOOP_RX_CUT: assert property (
        loop_on |=> ADP_DSR_N == SLM_DEASSERT
            && ADP_RXD == $past(adp_txd_s))
        else $error("modem input reached adapter in loop-back");

    AST_LOOP_ROUTE: assert property (
        loop_on |=> ADP_DCD_N == $past(adp_dtr_s)
            && ADP_CTS_N == $past(adp_rts_s))
        else $error("loop-back routing wrong");

    AST_ECHO_DATA: assert property (
        echo_on |=> MDM_TXD == $past(mdm_rxd_s))
        else $error("received data not echoed");

    AST_ECHO_RTS: assert property (
        echo_on |=> MDM_RTS_N == SLM_ASSERT)
        else $error("request-to-send not asserted in echo");

    // adapter still hears the line in echo
    AST_ECHO_RX_KEEP: assert property (
        echo_on |=> ADP_RXD == $past(mdm_rxd_s))
        else $error("adapter lost the line in echo");

    AST_NORMAL_PASS: assert property (
        !loop_on && !echo_on |=> MDM_TXD == $past(adp_txd_s)
            && ADP_RXD == $past(mdm_rxd_s)
            && ADP_CTS_N == $past(mdm_cts_s))
        else $error("normal path altered");

    AST_TICK_SPACING: assert property (
        BIT_TICK |-> rises_since_reg == 5'(SLM_EXT_DIV))
        else $error("bit tick spacing not sixteen edges");

    AST_TICK_ONLY_EXT: assert property (
        !ext_mode |=> !BIT_TICK)
        else $error("bit tick outside external mode");

    AST_APB_CTRL_WRITE: assert property (
        wr_ctrl |=> ctrl_reg == $past(PWDATA[7:0]) && PREADY)
        else $error("control write lost");

    // Zero wait states once out of reset
    AST_APB_NO_WAIT: assert property (PSEL && PENABLE |-> PREADY)
        else $error("wait state inserted");

    // Unmapped offsets answer with an error
    AST_APB_ERR: assert property (PSEL && !PENABLE && !addr_ok |=> PSLVERR)
        else $error("unmapped access not refused");
endmodule

/* slm_modem.sv */
// Modem-side partner model driving the modem line inputs
`timescale 1ns/10ps
module slm_modem #(
    parameter int LAT = 2
) (
    input wire logic clk,
    input wire logic [3:0] lines,
    output logic rxd,
    output logic dcd_n,
    output logic cts_n,
    output logic dsr_n
);
    logic [3:0] pipe_reg [LAT];
    // Slow answer: lines reach the block LAT edges late
    initial begin
        for (int i = 0; i < LAT; i++) begin
            pipe_reg[i] = 4'hF;
        end
    end
    always @(posedge clk) begin
        pipe_reg[0] <= lines;
        for (int i = 1; i < LAT; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
        end
    end
    assign {rxd, dcd_n, cts_n, dsr_n} = pipe_reg[LAT-1];
endmodule

/* slm_bench.sv */
// Self-checking bench for the loop-back steering block
`timescale 1ns/10ps
module slm_bench;
    import slm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, loop_sel = 1'b0, ext = 1'b0, probe = 1'b0;
    logic [SLM_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, tick, rxd, dcd, cts, dsr, mrxd, mdcd, mcts, mdsr;
    logic [2:0] a = 3'h7, mo;
    logic [3:0] m = 4'hF, ao;
    logic [32:0] rd_q[$];
    logic [6:0] pin_q[$];
    logic [31:0] rnd = 32'hBD7D5C5F;
    int err_count = 0, comparisons = 0, cyc = 0, ticks = 0, t0;
    logic [32:0] st_exp;
    // Status picture for echo with remote set-up in external mode
    assign st_exp = {1'b0, 21'h0, a[0], a[1], a[2],
        m[0], m[1], m[2], m[3], 4'hE};
    always #25 clk = ~clk;
    slm_top u_slm_top (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LOCAL_LOOP_SELECT(loop_sel), .EXT_CLK(ext), .ADP_TXD(a[2]),
        .ADP_DTR_N(a[1]), .ADP_RTS_N(a[0]), .ADP_RXD(ao[3]),
        .ADP_DCD_N(ao[2]), .ADP_CTS_N(ao[1]), .ADP_DSR_N(ao[0]),
        .MDM_TXD(mo[2]), .MDM_DTR_N(mo[1]), .MDM_RTS_N(mo[0]),
        .MDM_RXD(mrxd), .MDM_DCD_N(mdcd), .MDM_CTS_N(mcts),
        .MDM_DSR_N(mdsr), .BIT_TICK(tick));
    slm_modem #(.LAT(2)) u_slm_modem (.clk(clk), .lines(m), .rxd(mrxd),
        .dcd_n(mdcd), .cts_n(mcts), .dsr_n(mdsr));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    // New random lines on both sides, then one expected pin picture
    task automatic step(input logic lp, input logic ec);
        rnd = lfsr(rnd);
        @(posedge clk);
        a <= rnd[2:0];
        m <= rnd[6:3];
        repeat (12) @(posedge clk);
        if (lp) pin_q.push_back({a, 1'b1, 3'h7});
        else pin_q.push_back({m, ec ? m[3] : a[2], a[1], ec ? 1'b0 : a[0]});
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask
    task automatic rises(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk) ext <= 1'b1;
            repeat (4) @(posedge clk) ext <= 1'b0;
        end
        repeat (10) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (tick === 1'b1) ticks++;
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size())
            chk(rd_q.pop_front(), {pslverr, prdata});
        if (probe && pin_q.size()) chk({26'h0, pin_q.pop_front()},
            {26'h0, ao, mo});
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Unmapped write must leave both registers alone
        apb(1'b1, 8'h0C, 32'hFF);
        rd(SLM_CTRL_OFS, {1'b0, 24'h0, SLM_CTRL_RST});
        rd(SLM_CMD_OFS, {1'b0, 24'h0, SLM_CMD_RST});
        rd(8'h0C, {1'b1, 32'h0}); // Unmapped place refused
        repeat (6) step(1'b0, 1'b0);
        // Only idle EXT_CLK so far, so the tick phase starts at zero
        t0 = ticks;
        rises(32);
        chk(33'(t0 + 2), 33'(ticks));
        apb(1'b1, SLM_CTRL_OFS, 32'h1);
        rises(16);
        chk(33'(t0 + 2), 33'(ticks));
        apb(1'b1, SLM_CTRL_OFS, 32'h0);
        rises(16);
        chk(33'(t0 + 3), 33'(ticks));
        loop_sel <= 1'b1;
        repeat (6) step(1'b1, 1'b0);
        loop_sel <= 1'b0;
        apb(1'b1, SLM_CTRL_OFS, 32'h20);
        step(1'b1, 1'b0);
        apb(1'b1, SLM_CTRL_OFS, 32'h10);
        apb(1'b1, SLM_CMD_OFS, 32'h19);
        repeat (6) step(1'b0, 1'b1);
        rd(SLM_STAT_OFS, st_exp);
        rd(SLM_CMD_OFS, {1'b0, 32'h19});
        finish_test();
    end
endmodule
